// >>> hwds_bench.sv
// Self-checking bench for the demand sequencer
`timescale 1ns/1ns
`default_nettype none
module hwds_bench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic signed [11:0] lv [5];
    logic ok [5];
    hwds_pkg::hwds_temp_t tt [5];
    logic headerIsControl, preheatStartReq, tapDemand, dhwCall, centralHeatDemand, leadLagDemand;
    hwds_pkg::hwds_band_t dhwBand, plateBand, storeBand, activeBand;
    logic signed [11:0] stepOffset, frostOutdoorSetpoint;
    logic [15:0] preheatMinOnS, storeTimeS, frostOverrunS;
    logic storeEnable, frostEnable, preheatActive, tapSetEvent, pidRestart, pidBypass;
    logic dhwPumpReq, chPumpFrostReq, burnerDemand;
    logic [7:0] rateRequest;
    hwds_pkg::hwds_src_t burnerSource;
    logic [8:0] obs, m;
    logic [8:0] expQ [$];
    logic [8:0] mskQ [$];
    time dueQ [$];
    int n_errors = 0;
    int n_checks = 0;
    int seed = 32'h5A3A;

    always #25 ref_clk = ~ref_clk;
    for (genvar i = 0; i < 5; i++) begin : g_sens
        hwds_sensor u_sens (.ref_clk(ref_clk), .level(lv[i]), .ok(ok[i]), .t(tt[i]));
    end
    // Short tick and tap timer keep the run brief
    hwds_top #(.TICK_CYCLES(10), .TAP_TIMER_S(3)) dut (
        .ref_clk(ref_clk), .srst(srst), .dhwTemp(tt[0]), .inletTemp(tt[1]), .outletTemp(tt[2]),
        .headerTemp(tt[3]), .outdoorTemp(tt[4]), .headerIsControl(headerIsControl),
        .preheatStartReq(preheatStartReq), .tapDemand(tapDemand), .dhwCall(dhwCall),
        .centralHeatDemand(centralHeatDemand), .leadLagDemand(leadLagDemand),
        .dhwBand(dhwBand), .plateBand(plateBand), .storeBand(storeBand), .stepOffset(stepOffset),
        .preheatMinOnS(preheatMinOnS), .storeTimeS(storeTimeS), .frostOverrunS(frostOverrunS),
        .storeEnable(storeEnable), .frostEnable(frostEnable),
        .frostOutdoorSetpoint(frostOutdoorSetpoint), .preheatActive(preheatActive),
        .tapSetEvent(tapSetEvent), .pidRestart(pidRestart), .pidBypass(pidBypass),
        .rateRequest(rateRequest), .activeBand(activeBand), .dhwPumpReq(dhwPumpReq),
        .chPumpFrostReq(chPumpFrostReq), .burnerDemand(burnerDemand),
        .burnerSource(burnerSource));
    assign obs = {preheatActive, tapSetEvent, pidRestart, dhwPumpReq, chPumpFrostReq,
        burnerDemand, burnerSource};

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask
    // Due time stops a note from being judged in its own time step
    always @(posedge ref_clk) begin
        while (dueQ.size() > 0 && dueQ[0] <= $time) begin
            void'(dueQ.pop_front());
            m = mskQ.pop_front();
            check(obs & m, expQ.pop_front() & m);
        end
    end
    task automatic note(input logic [8:0] e, input logic [8:0] mk);
        expQ.push_back(e);
        mskQ.push_back(mk);
        dueQ.push_back($time + 1);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic fstep(input logic signed [11:0] o, h, od, input logic ook, odok, hc,
        input int w, input logic [8:0] e, mk);
        lv[2] <= o;
        lv[3] <= h;
        lv[4] <= od;
        ok[2] <= ook;
        ok[4] <= odok;
        headerIsControl <= hc;
        cyc(w);
        note(e, mk);
    endtask

    initial begin
        cyc(3000);
        n_errors++;
        end_of_test;
    end
    initial begin
        lv = '{12'sh12C, 12'sh1F4, 12'sh258, 12'sh258, 12'sh258};
        ok = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        {headerIsControl, preheatStartReq, tapDemand, dhwCall} = 4'h0;
        {centralHeatDemand, leadLagDemand, storeEnable, frostEnable} = 4'h0;
        dhwBand = '{12'sh1F4, 12'sh028, 12'sh014};
        plateBand = '{12'sh190, 12'sh014, 12'sh014};
        storeBand = '{12'sh1C2, 12'sh01E, 12'sh00A};
        stepOffset = 12'sh005;
        frostOutdoorSetpoint = 12'sh0C8;
        preheatMinOnS = 16'h0001;
        storeTimeS = 16'h0004;
        frostOverrunS = 16'h0001;
        cyc(16);
        srst <= 1'b0;
        cyc(1);
        note(9'h000, 9'h1FF);
        tapDemand <= 1'b1;
        preheatStartReq <= 1'b1;
        cyc(4);
        note(9'h000, 9'h100);
        preheatStartReq <= 1'b0;
        tapDemand <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            cyc(1);
            preheatStartReq <= 1'b1;
            cyc(1);
            preheatStartReq <= 1'b0;
            cyc(1);
            note(9'h104, 9'h107);
            tapDemand <= 1'b1;
            cyc(2);
            case (k)
                0: lv[1] <= 12'sh1C2;
                1: lv[0] <= 12'sh1F4;
                default: lv[0] <= 12'sh1A4;
            endcase
            if (k == 0) begin
                cyc(12);
                note(9'h100, 9'h100);
            end
            for (int j = 0; j < 200 && preheatActive === 1'b1; j++) @(negedge ref_clk);
            note(9'h0C0, 9'h1C0);
            @(posedge ref_clk);
            tapDemand <= 1'b0;
            lv[0] <= 12'sh12C;
            lv[1] <= 12'sh1F4;
        end
        storeEnable <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            dhwCall <= 1'b1;
            cyc(3);
            note(9'h022, 9'h027);
            dhwCall <= 1'b0;
            cyc(3);
            note(9'h025, 9'h027);
            if (k == 2) begin
                cyc(17);
                dhwCall <= 1'b1;
                cyc(3);
                dhwCall <= 1'b0;
                cyc(20);
                note(9'h025, 9'h027);
            end else begin
                centralHeatDemand <= (k == 0);
                leadLagDemand <= (k == 1);
                cyc(3);
                note(k ? 9'h003 : 9'h001, 9'h007);
                centralHeatDemand <= 1'b0;
                leadLagDemand <= 1'b0;
                cyc(3);
                note(9'h025, 9'h027);
            end
            cyc(40);
            note(9'h000, 9'h027);
        end
        storeEnable <= 1'b0;
        dhwCall <= 1'b1;
        cyc(3);
        dhwCall <= 1'b0;
        cyc(4);
        note(9'h000, 9'h027);
        frostEnable <= 1'b1;
        lv[1] <= 12'sh12C;
        ok[1] <= 1'b0;
        fstep(12'sh12C, 12'sh258, 12'sh258, 0, 0, 0, 8, 9'h000, 9'h018);
        fstep(12'(32'h12C + ($random(seed) & 32'h3F)), 12'sh258, 12'sh258, 1, 0, 0, 8,
            9'h01E, 9'h01F);
        fstep(12'sh258, 12'sh258, 12'sh258, 1, 0, 0, 8, 9'h000, 9'h00F);
        fstep(12'sh258, 12'sh258, 12'sh258, 1, 0, 0, 40, 9'h000, 9'h010);
        fstep(12'sh258, 12'sh190, 12'sh258, 1, 0, 1, 8, 9'h010, 9'h018);
        fstep(12'sh258, 12'sh258, 12'sh064, 1, 1, 0, 8, 9'h010, 9'h010);
        fstep(12'sh258, 12'sh258, 12'sh0F0, 1, 1, 0, 40, 9'h010, 9'h010);
        fstep(12'sh258, 12'sh258, 12'sh0F5, 1, 1, 0, 40, 9'h000, 9'h010);
        cyc(4);
        end_of_test;
    end
endmodule
`default_nettype wire

// >>> hwds_pkg.sv
// Package of constants and carriers for the hot water demand sequencer
// Operation
// - No preheat start during tap; track tap flag
// - Start one-minute timer when inlet cooled
// - End preheat, force tap set event
// - Preheat selects plate setpoint and hysteresis
// - Preheat requests minimum rate, bypassing loop
// - Restart integrator when preheat ends
// - Storage enable gates all storage settings
// - Storage demand follows satisfied normal demand
// - Storage thresholds from storage setpoint offsets
// - Storage ranks between normal and frost demands
// - New normal demand resets storage timer
// - Higher demands pause service, timer runs
// - Expired storage waits for next normal cycle
// - Storage thresholds follow hysteresis step offset
// - Storage shares loop, source and pump
// - Frost pump on below 45F or outdoor
// - Frost pump holds, then overrun timer
// - Frost pump request overrides all others
// - Frost burner below 38F at minimum rate
// - Frost burner ends above 50F and 41F
// - Invalid sensors ignored by frost logic
// - Preheat off threshold is setpoint plus hysteresis
package hwds_pkg;
    // Temperatures are signed tenths of a degree F
    localparam int TEMP_W = 12;
    localparam int TIME_W = 16;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;
    localparam int TAP_TIMER_S = 60;
    localparam logic signed [TEMP_W-1:0] FROST_PUMP_ON = 12'sh1C2;
    localparam logic signed [TEMP_W-1:0] FROST_OUT_OFF = 12'sh1F4;
    localparam logic signed [TEMP_W-1:0] FROST_OD_BAND = 12'sh028;
    localparam logic signed [TEMP_W-1:0] FROST_BURN_ON = 12'sh17C;
    localparam logic signed [TEMP_W-1:0] FROST_IN_OFF = 12'sh19A;
    localparam logic [7:0] RATE_MIN = 8'h00;

    typedef enum logic [2:0] {
        HWDS_SRC_NONE = 3'b000,
        HWDS_SRC_CH = 3'b001,
        HWDS_SRC_DHW = 3'b010,
        HWDS_SRC_LL = 3'b011,
        HWDS_SRC_PREHEAT = 3'b100,
        HWDS_SRC_STORE = 3'b101,
        HWDS_SRC_FROST = 3'b110
    } hwds_src_t;

    typedef struct packed {
        logic signed [TEMP_W-1:0] value;
        logic valid;
    } hwds_temp_t;

    typedef struct packed {
        logic signed [TEMP_W-1:0] setpoint;
        logic signed [TEMP_W-1:0] onHyst;
        logic signed [TEMP_W-1:0] offHyst;
    } hwds_band_t;
endpackage

// >>> hwds_props.sv
// Port checker for the demand sequencer
`timescale 1ns/1ns
`default_nettype none
module hwds_props #(
    parameter int TICK_CYCLES = hwds_pkg::TICK_CYCLES,
    parameter int TAP_TIMER_S = hwds_pkg::TAP_TIMER_S
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Inputs
    input wire hwds_pkg::hwds_temp_t outletTemp,
    input wire logic headerIsControl,
    input wire logic tapDemand,
    input wire logic dhwCall,
    input wire logic centralHeatDemand,
    input wire logic leadLagDemand,
    input wire hwds_pkg::hwds_band_t plateBand,
    input wire hwds_pkg::hwds_band_t storeBand,
    input wire logic signed [hwds_pkg::TEMP_W-1:0] stepOffset,
    input wire logic frostEnable,
    // Outputs
    input wire logic preheatActive,
    input wire logic tapSetEvent,
    input wire logic pidRestart,
    input wire logic pidBypass,
    input wire logic [7:0] rateRequest,
    input wire hwds_pkg::hwds_band_t activeBand,
    input wire logic chPumpFrostReq,
    input wire hwds_pkg::hwds_src_t burnerSource
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic higher;
    assign higher = centralHeatDemand || dhwCall || leadLagDemand;
    sequence s_phEnd;
        $fell(preheatActive);
    endsequence
    // Valid flag is synchronised, so the cold reading must persist first
    sequence s_cold;
        frostEnable && !headerIsControl && outletTemp.valid
            && outletTemp.value < hwds_pkg::FROST_PUMP_ON;
    endsequence
    a_bypass_tracks: assert property (pidBypass == preheatActive)
        else $error("bypass differs from preheat");
    a_rate_minimum: assert property (preheatActive |-> rateRequest == hwds_pkg::RATE_MIN)
        else $error("rate not minimum in preheat");
    a_start_no_tap: assert property ($rose(preheatActive) |-> !$past(tapDemand))
        else $error("preheat started during tap");
    a_end_restart: assert property (s_phEnd |-> pidRestart)
        else $error("no integrator restart");
    a_tap_event: assert property (tapSetEvent |-> s_phEnd ##1 !tapSetEvent)
        else $error("tap event misplaced");
    a_plate_band: assert property (preheatActive |-> activeBand == $past(plateBand))
        else $error("plate band not selected");
    a_frost_pump: assert property (s_cold [*6] |=> chPumpFrostReq)
        else $error("frost pump missing");
    a_store_rank: assert property (burnerSource == hwds_pkg::HWDS_SRC_STORE |-> !$past(higher))
        else $error("storage above higher demand");
    a_frost_rank: assert property (burnerSource == hwds_pkg::HWDS_SRC_FROST |-> !$past(higher))
        else $error("frost above other demand");
    a_store_band: assert property (burnerSource == hwds_pkg::HWDS_SRC_STORE
            |-> activeBand.setpoint == $past(storeBand.setpoint)
            && activeBand.onHyst == 12'($past(storeBand.onHyst) + $past(stepOffset))
            && activeBand.offHyst == 12'($past(storeBand.offHyst) + $past(stepOffset)))
        else $error("storage band wrong");
endmodule
bind hwds_top hwds_props #(.TICK_CYCLES(TICK_CYCLES), .TAP_TIMER_S(TAP_TIMER_S)) u_props (
    .ref_clk(ref_clk), .srst(srst), .outletTemp(outletTemp), .headerIsControl(headerIsControl),
    .tapDemand(tapDemand), .dhwCall(dhwCall), .centralHeatDemand(centralHeatDemand),
    .leadLagDemand(leadLagDemand), .plateBand(plateBand), .frostEnable(frostEnable),
    .storeBand(storeBand), .stepOffset(stepOffset),
    .preheatActive(preheatActive), .tapSetEvent(tapSetEvent), .pidRestart(pidRestart),
    .pidBypass(pidBypass), .rateRequest(rateRequest), .activeBand(activeBand),
    .chPumpFrostReq(chPumpFrostReq), .burnerSource(burnerSource));
`default_nettype wire

// >>> hwds_sensor.sv
// Sensor model: reading plus validity, noise when invalid
`timescale 1ns/1ns
`default_nettype none
module hwds_sensor (
    // Clock
    input wire logic ref_clk,
    // Commanded reading
    input wire logic signed [11:0] level,
    input wire logic ok,
    // Sensor output
    output hwds_pkg::hwds_temp_t t
);
    logic flip = 1'b0;
    // Disconnected sensor never repeats a plausible reading
    always @(posedge ref_clk) flip <= ~flip;
    assign t = '{value: ok ? level : (flip ? ~level : level ^ 12'h5A5), valid: ok};
endmodule
`default_nettype wire

// >>> hwds_sync.sv
// Three-stage synchroniser for external levels
`timescale 1ns/1ns
`default_nettype none
module hwds_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Level in and out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } hwds_sync_state_t;
    hwds_sync_state_t st_reg;
    hwds_sync_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // Bit changes only once the later stages agree
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule
`default_nettype wire

// >>> hwds_tick.sv
// Whole-second tick divider
`timescale 1ns/1ns
`default_nettype none
module hwds_tick #(
    parameter int CYCLES = hwds_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Tick
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } hwds_tick_state_t;
    hwds_tick_state_t st_reg;
    hwds_tick_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.cnt >= 32'(CYCLES - 1)) begin
            st_next.cnt = 32'h0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule
`default_nettype wire

// >>> hwds_top.sv
// Hot water demand sequencer: preheat, storage and frost demand logic
`timescale 1ns/1ns
`default_nettype none
module hwds_top #(
    parameter int TICK_CYCLES = hwds_pkg::TICK_CYCLES,
    parameter int TAP_TIMER_S = hwds_pkg::TAP_TIMER_S
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Sensors
    input wire hwds_pkg::hwds_temp_t dhwTemp,
    input wire hwds_pkg::hwds_temp_t inletTemp,
    input wire hwds_pkg::hwds_temp_t outletTemp,
    input wire hwds_pkg::hwds_temp_t headerTemp,
    input wire hwds_pkg::hwds_temp_t outdoorTemp,
    input wire logic headerIsControl,
    // Demand inputs, already in this clock domain
    input wire logic preheatStartReq,
    input wire logic tapDemand,
    input wire logic dhwCall,
    input wire logic centralHeatDemand,
    input wire logic leadLagDemand,
    // Configuration
    input wire hwds_pkg::hwds_band_t dhwBand,
    input wire hwds_pkg::hwds_band_t plateBand,
    input wire hwds_pkg::hwds_band_t storeBand,
    input wire logic signed [hwds_pkg::TEMP_W-1:0] stepOffset,
    input wire logic [hwds_pkg::TIME_W-1:0] preheatMinOnS,
    input wire logic [hwds_pkg::TIME_W-1:0] storeTimeS,
    input wire logic [hwds_pkg::TIME_W-1:0] frostOverrunS,
    input wire logic storeEnable,
    input wire logic frostEnable,
    input wire logic signed [hwds_pkg::TEMP_W-1:0] frostOutdoorSetpoint,
    // Outputs
    output logic preheatActive,
    output logic tapSetEvent,
    output logic pidRestart,
    output logic pidBypass,
    output logic [7:0] rateRequest,
    output hwds_pkg::hwds_band_t activeBand,
    output logic dhwPumpReq,
    output logic chPumpFrostReq,
    output logic burnerDemand,
    output hwds_pkg::hwds_src_t burnerSource
);
    typedef struct packed {
        logic preheat;
        logic tapFlag;
        logic signed [hwds_pkg::TEMP_W-1:0] inletLatch;
        logic tapTimerRun;
        logic [hwds_pkg::TIME_W-1:0] tapTimer;
        logic [hwds_pkg::TIME_W-1:0] minOnTimer;
        logic tapPrev;
        logic callPrev;
        logic storeArmed;
        logic storeActive;
        logic [hwds_pkg::TIME_W-1:0] storeTimer;
        logic frostPump;
        logic overrunRun;
        logic [hwds_pkg::TIME_W-1:0] overrunTimer;
        logic frostBurn;
        logic preheatOut;
        logic tapSet;
        logic pidRst;
        logic [7:0] rate;
        hwds_pkg::hwds_band_t band;
        logic dhwPump;
        logic chPump;
        logic burner;
        hwds_pkg::hwds_src_t src;
    } hwds_state_t;
    hwds_state_t st_reg;
    hwds_state_t st_next;

    logic tick;
    logic [64:0] syncIn;
    logic [64:0] syncOut;
    hwds_pkg::hwds_temp_t sDhw;
    hwds_pkg::hwds_temp_t sIn;
    hwds_pkg::hwds_temp_t sOut;
    hwds_pkg::hwds_temp_t sHdr;
    hwds_pkg::hwds_temp_t sOd;

    hwds_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .srst(srst),
        .tick(tick)
    );

    // Readings travel with their flags, so a dying sensor's noise is never taken as valid
    assign syncIn = {dhwTemp, inletTemp, outletTemp, headerTemp, outdoorTemp};
    assign {sDhw, sIn, sOut, sHdr, sOd} = syncOut;

    hwds_sync #(
        .W(65)
    ) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .din(syncIn),
        .dout(syncOut)
    );

    function automatic logic [hwds_pkg::TIME_W-1:0] countDown(
        input logic [hwds_pkg::TIME_W-1:0] t,
        input logic en
    );
        if (en && t != '0) begin
            return t - 16'h1;
        end
        return t;
    endfunction

    function automatic logic signed [hwds_pkg::TEMP_W-1:0] tAdd(
        input logic signed [hwds_pkg::TEMP_W-1:0] a,
        input logic signed [hwds_pkg::TEMP_W-1:0] b
    );
        return a + b;
    endfunction

    always_comb begin
        logic dhwOk;
        logic inOk;
        logic outOk;
        logic odOk;
        logic ctlOk;
        logic signed [hwds_pkg::TEMP_W-1:0] ctlT;
        logic signed [hwds_pkg::TEMP_W-1:0] offThr;
        logic endPreheat;
        logic higher;
        logic pumpOn;
        logic pumpHold;
        logic burnOn;
        logic burnOff;
        dhwOk = sDhw.valid;
        inOk = sIn.valid;
        outOk = sOut.valid;
        odOk = sOd.valid;
        ctlOk = headerIsControl ? sHdr.valid : sOut.valid;
        ctlT = headerIsControl ? sHdr.value : sOut.value;
        offThr = tAdd(plateBand.setpoint, plateBand.offHyst);
        endPreheat = 1'b0;
        higher = 1'b0;
        pumpOn = 1'b0;
        pumpHold = 1'b0;
        burnOn = 1'b0;
        burnOff = 1'b0;
        st_next = st_reg;
        st_next.tapSet = 1'b0;
        st_next.pidRst = 1'b0;
        st_next.tapPrev = tapDemand;
        st_next.callPrev = dhwCall;

        // Preheat and tap during preheat
        st_next.minOnTimer = countDown(st_reg.minOnTimer, tick);
        if (!st_reg.preheat) begin
            if (preheatStartReq && !tapDemand) begin
                st_next.preheat = 1'b1;
                st_next.tapFlag = 1'b0;
                st_next.tapTimerRun = 1'b0;
                st_next.inletLatch = sIn.value;
                st_next.minOnTimer = preheatMinOnS;
            end
        end else begin
            if (tapDemand && !st_reg.tapPrev) begin
                st_next.tapFlag = 1'b1;
            end
            if (st_reg.tapTimerRun) begin
                st_next.tapTimer = countDown(st_reg.tapTimer, tick);
            end
            if (st_reg.tapFlag) begin
                if (inOk && sIn.value < st_reg.inletLatch && !st_reg.tapTimerRun) begin
                    st_next.tapTimerRun = 1'b1;
                    st_next.tapTimer = 16'(TAP_TIMER_S);
                end
                if ((st_reg.tapTimerRun && st_reg.tapTimer == '0)
                        || (dhwOk && sDhw.value >= sIn.value)) begin
                    endPreheat = 1'b1;
                    st_next.tapSet = 1'b1;
                end
            end
            if (dhwOk && sDhw.value >= offThr && st_reg.minOnTimer == '0) begin
                endPreheat = 1'b1;
                st_next.tapSet = st_reg.tapFlag;
            end
            if (endPreheat) begin
                st_next.preheat = 1'b0;
                st_next.tapTimerRun = 1'b0;
                st_next.pidRst = 1'b1;
            end
        end

        // Storage demand
        higher = centralHeatDemand || leadLagDemand;
        if (!storeEnable) begin
            st_next.storeArmed = 1'b0;
            st_next.storeActive = 1'b0;
        end else if (dhwCall) begin
            st_next.storeArmed = 1'b1;
            st_next.storeActive = 1'b0;
        end else if (st_reg.callPrev && st_reg.storeArmed) begin
            st_next.storeActive = 1'b1;
            st_next.storeArmed = 1'b0;
            st_next.storeTimer = storeTimeS;
        end else if (st_reg.storeActive) begin
            st_next.storeTimer = countDown(st_reg.storeTimer, tick);
            if (st_reg.storeTimer == '0) begin
                st_next.storeActive = 1'b0;
            end
        end

        // Central heat frost pump
        pumpOn = (ctlOk && ctlT < hwds_pkg::FROST_PUMP_ON)
            || (odOk && sOd.value < frostOutdoorSetpoint);
        // Missing outdoor sensor cannot hold the pump on
        pumpHold = (odOk && sOd.value
                <= tAdd(frostOutdoorSetpoint, hwds_pkg::FROST_OD_BAND))
            || (outOk && sOut.value <= hwds_pkg::FROST_OUT_OFF);
        if (!frostEnable) begin
            st_next.frostPump = 1'b0;
            st_next.overrunRun = 1'b0;
        end else if (pumpOn) begin
            st_next.frostPump = 1'b1;
            st_next.overrunRun = 1'b0;
        end else if (st_reg.frostPump && !pumpHold) begin
            st_next.frostPump = 1'b0;
            st_next.overrunRun = 1'b1;
            st_next.overrunTimer = frostOverrunS;
        end else if (st_reg.overrunRun) begin
            st_next.overrunTimer = countDown(st_reg.overrunTimer, tick);
            if (st_reg.overrunTimer == '0) begin
                st_next.overrunRun = 1'b0;
            end
        end

        // Frost burner demand, invalid sensors drop out
        burnOn = ctlOk && outOk && sOut.value < hwds_pkg::FROST_BURN_ON;
        burnOff = (!outOk || sOut.value > hwds_pkg::FROST_OUT_OFF)
            && (!inOk || sIn.value > hwds_pkg::FROST_IN_OFF);
        if (!frostEnable || burnOff) begin
            st_next.frostBurn = 1'b0;
        end else if (burnOn) begin
            st_next.frostBurn = 1'b1;
        end

        // Arbitration and outputs
        st_next.burner = 1'b1;
        st_next.rate = hwds_pkg::RATE_MIN;
        st_next.band = dhwBand;
        if (centralHeatDemand) begin
            st_next.src = hwds_pkg::HWDS_SRC_CH;
        end else if (dhwCall || tapDemand) begin
            st_next.src = hwds_pkg::HWDS_SRC_DHW;
        end else if (leadLagDemand) begin
            st_next.src = hwds_pkg::HWDS_SRC_LL;
        end else if (st_next.preheat) begin
            st_next.src = hwds_pkg::HWDS_SRC_PREHEAT;
        end else if (st_next.storeActive) begin
            st_next.src = hwds_pkg::HWDS_SRC_STORE;
        end else if (st_next.frostBurn) begin
            st_next.src = hwds_pkg::HWDS_SRC_FROST;
        end else begin
            st_next.src = hwds_pkg::HWDS_SRC_NONE;
            st_next.burner = 1'b0;
        end
        if (st_next.preheat) begin
            st_next.band = plateBand;
        end else if (st_next.storeActive && !higher && !dhwCall) begin
            st_next.band.setpoint = storeBand.setpoint;
            st_next.band.onHyst = tAdd(storeBand.onHyst, stepOffset);
            st_next.band.offHyst = tAdd(storeBand.offHyst, stepOffset);
        end
        st_next.preheatOut = st_next.preheat;
        st_next.dhwPump = dhwCall || st_next.storeActive;
        st_next.chPump = st_next.frostPump || st_next.overrunRun;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign preheatActive = st_reg.preheatOut;
    assign tapSetEvent = st_reg.tapSet;
    assign pidRestart = st_reg.pidRst;
    assign pidBypass = st_reg.preheatOut;
    assign rateRequest = st_reg.rate;
    assign activeBand = st_reg.band;
    assign dhwPumpReq = st_reg.dhwPump;
    assign chPumpFrostReq = st_reg.chPump;
    assign burnerDemand = st_reg.burner;
    assign burnerSource = st_reg.src;
endmodule
`default_nettype wire
